// ---- afs_regs.svh ----
// constants for the appliance fault supervisor
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH
`define AFS_CLK_HZ 64'd250000000
`define AFS_FLOOD_S 64'd30
`define AFS_STALL_S 64'd30
`define AFS_BASKET_MIN 64'd2
`define AFS_RETRY_MIN 64'd8
`define AFS_OOB_HOLD_S 64'd10
`define AFS_SEC_PER_MIN 64'd60
`define AFS_TOPUP_MAX 3'd4
`define AFS_LEVEL_EMPTY 8'h00
`define AFS_FLOOD_LEVEL 8'hc0
`define AFS_CODE_NONE 8'h00
`define AFS_CODE_CTRL_MEM 8'h01
`define AFS_CODE_PRESS_READ 8'h02
`define AFS_CODE_CTRL_MEM_ALT 8'h03
`define AFS_CODE_PRESS_INVALID 8'h06
`define AFS_CODE_DISP_MEM 8'h07
`define AFS_CODE_LOCATION 8'h09
`define AFS_CODE_TEMP_LOW 8'h0a
`define AFS_CODE_PRESS_NEG 8'h0b
`define AFS_CODE_FLOOD 8'h0c
`define AFS_CODE_TOPUP 8'h24
`define AFS_CODE_STALL 8'h25
`define AFS_CODE_EMPTY_AGIT 8'h26
`define AFS_CODE_BASKET 8'h28
`define AFS_CODE_TEMP_HIGH 8'h29
`define AFS_CODE_OOB 8'h2b
`define AFS_CODE_SPIN_WATER 8'h2c
`define AFS_CODE_BASKET_UNK 8'h2f
`endif

// ---- afs_pkg.sv ----
// types shared by the fault supervisor files
package afs_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_RETRY = 2'b01,
        ST_FAULT = 2'b10,
        ST_DIAG = 2'b11
    } afs_state_type;
    typedef struct packed {
        logic power_btn;
        logic advance_btn;
        logic diag_req;
        logic restart_en;
        logic agitating;
        logic draining;
        logic spinning;
        logic basket_check;
        logic topup;
        logic basket_engaged;
        logic basket_valid;
        logic ctrl_mem_err;
        logic ctrl_mem_err_alt;
        logic press_read_err;
        logic press_invalid;
        logic press_negative;
        logic disp_mem_err;
        logic location_sw;
        logic location_mem;
        logic temp_open;
        logic temp_low;
        logic temp_high;
        logic oob_sw;
        logic oob_open;
        logic [7:0] level;
    } afs_pins_type;
    typedef struct packed {
        logic [7:0] leds;
        logic beep;
        logic halt;
        logic pump;
        logic restart;
        logic diag;
        logic switch_view;
    } afs_ind_type;
endpackage

// ---- afs_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module afs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    generate
        if (WIDTH < 1) begin : g_bad
            $error("afs_sync: WIDTH must be at least 1");
        end
    endgenerate
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- afs_timer.sv ----
// qualifying timer: done holds once run has stayed high for CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module afs_timer #(
    parameter int WIDTH = 40,
    parameter longint unsigned CYCLES = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic run_in,
    output logic done_out
);
    localparam logic [WIDTH-1:0] LIMIT = WIDTH'(CYCLES);
    logic [WIDTH-1:0] cnt_q;
    generate
        if (WIDTH < 2 || WIDTH > 63 || CYCLES < 1 || CYCLES >= (64'd1 << WIDTH)) begin : g_bad
            $error("afs_timer: CYCLES does not fit WIDTH");
        end
    endgenerate
    // count stops at the limit so done stays until run drops
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_q <= '0;
        end else if (!run_in) begin
            cnt_q <= '0;
        end else if (cnt_q != LIMIT) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign done_out = (cnt_q == LIMIT);
endmodule
`default_nettype wire

// ---- afs_fault_supervisor.sv ----
// appliance fault supervisor: fault detection, fault display and diagnostic views
// Summary of operation
// - fault number shown in binary on eight progress leds, lit means one
// - each led has weight two to its position; lit weights sum to the code
// - in diagnostics, advance press toggles data view and switch-test view
// - power press in diagnostics returns the machine to normal running
// - on a fault halt the machine, show the code, beep continuously
// - memory errors give 1 or 3, pressure read 2, bad pressure 6, display 7
// - location switch differing from stored value gives code 9
// - open or too cold temperature sensor gives code 10
// - negative pressure while measuring level gives code 11
// - above flood level run pump, except in diagnostics; still above after 30 s gives 12
// - more than four top-ups in one agitate gives code 36
// - level unchanged over 30 s while draining gives code 37
// - empty level read while agitating gives code 38
// - basket stays disengaged with empty tub for 2 minutes gives 40
// - no valid basket status within that window gives 47 instead
// - temperature above upper limit gives code 41
// - balance switch stuck on or harness open gives code 43
// - water sensed during spin gives code 44
// - with restart enabled, retry up to 8 minutes before showing fault
`include "afs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module afs_fault_supervisor
    import afs_pkg::*;
#(
    parameter longint unsigned FLOOD_CYC = `AFS_FLOOD_S * `AFS_CLK_HZ,
    parameter longint unsigned STALL_CYC = `AFS_STALL_S * `AFS_CLK_HZ,
    parameter longint unsigned BASKET_CYC =
        `AFS_BASKET_MIN * `AFS_SEC_PER_MIN * `AFS_CLK_HZ,
    parameter longint unsigned RETRY_CYC =
        `AFS_RETRY_MIN * `AFS_SEC_PER_MIN * `AFS_CLK_HZ,
    parameter longint unsigned OOB_CYC = `AFS_OOB_HOLD_S * `AFS_CLK_HZ,
    parameter int TIMER_WIDTH = 40
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire afs_pins_type pins_in,
    output afs_ind_type ind_out
);
    afs_pins_type pin_s;
    afs_state_type state_q;
    afs_state_type state_d;
    afs_ind_type ind_q;
    logic [7:0] code_q;
    logic [7:0] raw_code;
    logic [7:0] last_level_q;
    logic [2:0] topup_cnt_q;
    logic pwr_q;
    logic adv_q;
    logic diag_req_q;
    logic topup_q;
    logic agit_q;
    logic pwr_edge;
    logic adv_edge;
    logic diag_edge;
    logic topup_edge;
    logic agit_start;
    logic level_empty;
    logic level_high;
    logic valid_seen_q;
    logic basket_run;
    logic stall_run;
    logic flood_done;
    logic stall_done;
    logic basket_done;
    logic retry_done;
    logic oob_done;
    logic f_location;
    logic f_temp_low;
    logic f_topup;
    logic f_oob;
    logic view_d;

    generate
        if (TIMER_WIDTH < 38 || TIMER_WIDTH > 63) begin : g_bad
            $error("afs_fault_supervisor: TIMER_WIDTH out of range");
        end
    endgenerate

    // every pin, level bus included, crosses in through two flops
    afs_sync #(
        .WIDTH($bits(afs_pins_type))
    ) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(pins_in),
        .q_out(pin_s)
    );

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pwr_q <= 1'b0;
            adv_q <= 1'b0;
            diag_req_q <= 1'b0;
            topup_q <= 1'b0;
            agit_q <= 1'b0;
        end else begin
            pwr_q <= pin_s.power_btn;
            adv_q <= pin_s.advance_btn;
            diag_req_q <= pin_s.diag_req;
            topup_q <= pin_s.topup;
            agit_q <= pin_s.agitating;
        end
    end

    assign pwr_edge = pin_s.power_btn && !pwr_q;
    assign adv_edge = pin_s.advance_btn && !adv_q;
    assign diag_edge = pin_s.diag_req && !diag_req_q;
    assign topup_edge = pin_s.topup && !topup_q;
    assign agit_start = pin_s.agitating && !agit_q;
    assign level_empty = (pin_s.level == `AFS_LEVEL_EMPTY);
    assign level_high = (pin_s.level > `AFS_FLOOD_LEVEL);

    // flood: pump runs while high outside diagnostics, timer measures how long pumping fails
    afs_timer #(
        .WIDTH(TIMER_WIDTH),
        .CYCLES(FLOOD_CYC)
    ) u_flood (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(level_high),
        .done_out(flood_done)
    );

    // level unchanged while draining means the pump is blocked
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            last_level_q <= `AFS_LEVEL_EMPTY;
        end else begin
            last_level_q <= pin_s.level;
        end
    end
    assign stall_run = pin_s.draining && (pin_s.level == last_level_q);

    afs_timer #(
        .WIDTH(TIMER_WIDTH),
        .CYCLES(STALL_CYC)
    ) u_stall (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(stall_run),
        .done_out(stall_done)
    );

    // top-ups counted per agitate phase; saturates one past the limit
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            topup_cnt_q <= 3'h0;
        end else if (agit_start) begin
            topup_cnt_q <= 3'h0;
        end else if (pin_s.agitating && topup_edge && topup_cnt_q <= `AFS_TOPUP_MAX) begin
            topup_cnt_q <= topup_cnt_q + 3'h1;
        end
    end
    assign f_topup = (topup_cnt_q > `AFS_TOPUP_MAX);

    // basket check window with an empty tub and a disengaged basket
    assign basket_run = pin_s.basket_check && level_empty && !pin_s.basket_engaged;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            valid_seen_q <= 1'b0;
        end else if (!basket_run) begin
            valid_seen_q <= 1'b0;
        end else if (pin_s.basket_valid) begin
            valid_seen_q <= 1'b1;
        end
    end

    afs_timer #(
        .WIDTH(TIMER_WIDTH),
        .CYCLES(BASKET_CYC)
    ) u_basket (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(basket_run),
        .done_out(basket_done)
    );

    // a stuck balance switch only counts once held for the hold time
    afs_timer #(
        .WIDTH(TIMER_WIDTH),
        .CYCLES(OOB_CYC)
    ) u_oob (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(pin_s.oob_sw),
        .done_out(oob_done)
    );
    assign f_oob = oob_done || pin_s.oob_open;

    afs_timer #(
        .WIDTH(TIMER_WIDTH),
        .CYCLES(RETRY_CYC)
    ) u_retry (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(state_q == ST_RETRY),
        .done_out(retry_done)
    );

    assign f_location = (pin_s.location_sw != pin_s.location_mem);
    assign f_temp_low = pin_s.temp_open || pin_s.temp_low;

    // lowest code wins when several faults show up together
    always_comb begin
        raw_code = `AFS_CODE_NONE;
        if (pin_s.ctrl_mem_err) begin
            raw_code = `AFS_CODE_CTRL_MEM;
        end else if (pin_s.press_read_err) begin
            raw_code = `AFS_CODE_PRESS_READ;
        end else if (pin_s.ctrl_mem_err_alt) begin
            raw_code = `AFS_CODE_CTRL_MEM_ALT;
        end else if (pin_s.press_invalid) begin
            raw_code = `AFS_CODE_PRESS_INVALID;
        end else if (pin_s.disp_mem_err) begin
            raw_code = `AFS_CODE_DISP_MEM;
        end else if (f_location) begin
            raw_code = `AFS_CODE_LOCATION;
        end else if (f_temp_low) begin
            raw_code = `AFS_CODE_TEMP_LOW;
        end else if (pin_s.press_negative) begin
            raw_code = `AFS_CODE_PRESS_NEG;
        end else if (level_high && flood_done) begin
            raw_code = `AFS_CODE_FLOOD;
        end else if (f_topup) begin
            raw_code = `AFS_CODE_TOPUP;
        end else if (stall_done) begin
            raw_code = `AFS_CODE_STALL;
        end else if (pin_s.agitating && level_empty) begin
            raw_code = `AFS_CODE_EMPTY_AGIT;
        end else if (basket_done && valid_seen_q) begin
            raw_code = `AFS_CODE_BASKET;
        end else if (pin_s.temp_high) begin
            raw_code = `AFS_CODE_TEMP_HIGH;
        end else if (f_oob) begin
            raw_code = `AFS_CODE_OOB;
        end else if (pin_s.spinning && !level_empty) begin
            raw_code = `AFS_CODE_SPIN_WATER;
        end else if (basket_done) begin
            raw_code = `AFS_CODE_BASKET_UNK;
        end
    end

    // fault state is left only by power removal, i.e. reset
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (raw_code != `AFS_CODE_NONE) begin
                    state_d = pin_s.restart_en ? ST_RETRY : ST_FAULT;
                end else if (diag_edge) begin
                    state_d = ST_DIAG;
                end
            end
            ST_RETRY: begin
                if (raw_code == `AFS_CODE_NONE) begin
                    state_d = ST_RUN;
                end else if (retry_done) begin
                    state_d = ST_FAULT;
                end
            end
            ST_FAULT: begin
                state_d = ST_FAULT;
            end
            ST_DIAG: begin
                if (pwr_edge) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // fault number captured on entry to fault; kept for the data view
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            code_q <= `AFS_CODE_NONE;
        end else if (state_q != ST_FAULT && state_d == ST_FAULT) begin
            code_q <= raw_code;
        end
    end

    // next view also picks the leds, so flag and pattern change on one edge
    assign view_d = (state_q == ST_DIAG) && (ind_q.switch_view ^ adv_edge);

    // outputs registered one clock behind the state
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ind_q <= '0;
        end else begin
            ind_q.pump <= level_high && state_q != ST_DIAG;
            ind_q.halt <= (state_q == ST_FAULT);
            ind_q.beep <= (state_q == ST_FAULT);
            ind_q.restart <= (state_q == ST_RETRY);
            ind_q.diag <= (state_q == ST_DIAG);
            ind_q.switch_view <= view_d;
            if (state_q == ST_FAULT) begin
                ind_q.leds <= code_q;
            end else if (state_q == ST_DIAG && view_d) begin
                ind_q.leds <= {6'h00, pin_s.oob_sw, pin_s.location_sw};
            end else if (state_q == ST_DIAG) begin
                ind_q.leds <= code_q;
            end else begin
                ind_q.leds <= `AFS_CODE_NONE;
            end
        end
    end
    assign ind_out = ind_q;

    function automatic logic [8:0] led_weight_sum(input logic [7:0] leds);
        logic [8:0] sum;
        sum = 9'h000;
        for (int i = 0; i < 8; i++) begin
            if (leds[i]) begin
                sum = sum + 9'(1 << i);
            end
        end
        return sum;
    endfunction

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_enter_fault;
        state_q != ST_FAULT ##1 state_q == ST_FAULT;
    endsequence

    sequence s_fault_shown;
        ind_out.halt && ind_out.beep && ind_out.leds == code_q;
    endsequence

    chk_fault_shown: assert property (s_enter_fault |=> s_fault_shown [*3])
        else $error("fault not shown with halt and beep");
    chk_led_weights: assert property (
        state_q == ST_FAULT |=> led_weight_sum(ind_out.leds) == {1'b0, code_q})
        else $error("led weights do not sum to fault code");
    chk_fault_capture: assert property (
        state_q == ST_RUN && raw_code != 8'h00 && !pin_s.restart_en
        |=> state_q == ST_FAULT && code_q == $past(raw_code))
        else $error("fault code not captured");
    chk_fault_hold: assert property (state_q == ST_FAULT |=> state_q == ST_FAULT)
        else $error("fault state left before reset");
    chk_view_toggle: assert property (
        state_q == ST_DIAG && $past(state_q) == ST_DIAG && adv_edge
        |=> ind_out.switch_view != $past(ind_out.switch_view))
        else $error("advance did not toggle view");
    chk_power_exit: assert property (state_q == ST_DIAG && pwr_edge |=> state_q == ST_RUN)
        else $error("power press did not leave diagnostics");
    chk_retry_first: assert property (
        state_q == ST_RUN && raw_code != 8'h00 && pin_s.restart_en |=> state_q == ST_RETRY)
        else $error("restart not attempted");
    chk_flood_pump: assert property (
        level_high && state_q == ST_RUN |=> ind_out.pump)
        else $error("pump not driven above flood level");
    chk_topup_limit: assert property (
        pin_s.agitating && !agit_start && topup_edge && topup_cnt_q == 3'h4
        |=> f_topup && raw_code != 8'h00)
        else $error("fifth top-up not flagged");
    chk_spin_water: assert property (
        pin_s.spinning && !level_empty |-> raw_code != 8'h00 && raw_code <= 8'h2c)
        else $error("water in spin not flagged");
endmodule
`default_nettype wire

// ---- afs_far_side.sv ----
// sensor and switch side of the washer, registered onto the supervisor pins
`timescale 1ns/1ps
`default_nettype none
module afs_far_side
    import afs_pkg::*;
(
    input wire logic clk_in,
    input wire afs_pins_type cmd_in,
    input wire afs_ind_type ind_in,
    output afs_pins_type pins_out
);
    // pins move only at the clock edge, like a sampled sensor board
    always_ff @(posedge clk_in) begin
        pins_out <= cmd_in;
    end
    // the beeper and leds are only watched by the bench, nothing loads them
    logic unused_ind;
    assign unused_ind = ^ind_in;
endmodule
`default_nettype wire

// ---- afs_fault_supervisor_tb.sv ----
// self-checking bench for the fault supervisor
`include "afs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module afs_fault_supervisor_tb
    import afs_pkg::*;
;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    afs_pins_type cmd = '0;
    afs_pins_type pins;
    afs_ind_type ind;
    afs_ind_type last = '0;
    afs_ind_type exp_q[$];
    int n_errors = 0;
    int check_count = 0;
    logic [31:0] lfsr = 32'hb1cf8cba;
    localparam logic [7:0] CODES [17] = '{`AFS_CODE_CTRL_MEM, `AFS_CODE_PRESS_READ,
        `AFS_CODE_CTRL_MEM_ALT, `AFS_CODE_PRESS_INVALID, `AFS_CODE_DISP_MEM,
        `AFS_CODE_LOCATION, `AFS_CODE_TEMP_LOW, `AFS_CODE_TEMP_LOW, `AFS_CODE_PRESS_NEG,
        `AFS_CODE_TEMP_HIGH, `AFS_CODE_OOB, `AFS_CODE_OOB, `AFS_CODE_SPIN_WATER,
        `AFS_CODE_EMPTY_AGIT, `AFS_CODE_STALL, `AFS_CODE_BASKET, `AFS_CODE_BASKET_UNK};

    // short timers keep the run small; expectations do not depend on them
    afs_fault_supervisor #(.FLOOD_CYC(40), .STALL_CYC(40), .BASKET_CYC(60),
        .RETRY_CYC(80), .OOB_CYC(30)) DUT (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .pins_in(pins),
        .ind_out(ind)
    );
    afs_far_side far (
        .clk_in(clk_in),
        .cmd_in(cmd),
        .ind_in(ind),
        .pins_out(pins)
    );

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    function automatic afs_ind_type mk(input logic [7:0] leds, input logic [5:0] f);
        return afs_ind_type'{leds, f[5], f[4], f[3], f[2], f[1], f[0]};
    endfunction

    function automatic afs_pins_type fault_pins(input int k, input afs_pins_type b);
        afs_pins_type p;
        p = b;
        case (k)
            0: p.ctrl_mem_err = 1'b1;
            1: p.press_read_err = 1'b1;
            2: p.ctrl_mem_err_alt = 1'b1;
            3: p.press_invalid = 1'b1;
            4: p.disp_mem_err = 1'b1;
            5: p.location_sw = 1'b1;
            6: p.temp_open = 1'b1;
            7: p.temp_low = 1'b1;
            8: p.press_negative = 1'b1;
            9: p.temp_high = 1'b1;
            10: p.oob_open = 1'b1;
            11: p.oob_sw = 1'b1;
            12: p.spinning = 1'b1;
            13: {p.agitating, p.level} = {1'b1, `AFS_LEVEL_EMPTY};
            14: p.draining = 1'b1;
            15: {p.basket_check, p.basket_valid, p.level} = {2'b11, `AFS_LEVEL_EMPTY};
            default: {p.basket_check, p.level} = {1'b1, `AFS_LEVEL_EMPTY};
        endcase
        return p;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // a changed output takes the oldest note; a change with no note is a mismatch
    always @(negedge clk_in) begin
        if (resetn_in !== 1'b1) begin
            last = ind;
        end else if (ind !== last) begin
            last = ind;
            if (exp_q.size() == 0) begin
                check(32'(ind), 32'hffffffff);
            end else begin
                check(32'(ind), 32'(exp_q.pop_front()));
            end
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // level is random but stays between empty and flood
    task automatic do_reset();
        afs_pins_type b;
        b = '0;
        lfsr = lfsr_next(lfsr);
        b.level = 8'h01 + 8'(lfsr % 32'hbf);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        cmd <= b;
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic finish_test(input string name);
        int i;
        i = 0;
        while (exp_q.size() != 0 && i < 2000) begin
            @(posedge clk_in);
            i++;
        end
        repeat (10) @(posedge clk_in);
        check(32'(exp_q.size()), 32'h0);
        $display("test %s ended", name);
    endtask

    // edge-detected inputs need a low synced sample between presses
    task automatic press(input int which);
        for (int v = 1; v >= 0; v--) begin
            case (which)
                0: cmd.power_btn <= v[0];
                1: cmd.advance_btn <= v[0];
                2: cmd.diag_req <= v[0];
                default: cmd.topup <= v[0];
            endcase
            repeat (4) @(posedge clk_in);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        n_errors++;
        print_verdict();
    end

    initial begin
        for (int k = 0; k < 17; k++) begin
            do_reset();
            exp_q.push_back(mk(CODES[k], 6'b110000));
            cmd <= fault_pins(k, cmd);
            finish_test("fault table");
        end
        do_reset();
        cmd.agitating <= 1'b1;
        // a top-up on the agitate start edge is lost to the count clear
        repeat (4) @(posedge clk_in);
        repeat (4) press(3);
        finish_test("four top-ups");
        exp_q.push_back(mk(`AFS_CODE_TOPUP, 6'b110000));
        press(3);
        finish_test("fifth top-up");
        do_reset();
        cmd.level <= `AFS_FLOOD_LEVEL;
        finish_test("at flood level");
        exp_q.push_back(mk(8'h00, 6'b001000));
        exp_q.push_back(mk(`AFS_CODE_FLOOD, 6'b111000));
        cmd.level <= `AFS_FLOOD_LEVEL + 8'h01;
        finish_test("flood");
        do_reset();
        cmd.restart_en <= 1'b1;
        cmd.ctrl_mem_err <= 1'b1;
        exp_q.push_back(mk(8'h00, 6'b000100));
        exp_q.push_back(mk(8'h00, 6'b000000));
        repeat (8) @(posedge clk_in);
        cmd.ctrl_mem_err <= 1'b0;
        finish_test("transient retry");
        exp_q.push_back(mk(8'h00, 6'b000100));
        exp_q.push_back(mk(`AFS_CODE_CTRL_MEM, 6'b110000));
        cmd.ctrl_mem_err <= 1'b1;
        finish_test("persistent retry");
        do_reset();
        {cmd.location_sw, cmd.location_mem} <= 2'b11;
        press(0);
        finish_test("power outside diag");
        exp_q.push_back(mk(8'h00, 6'b000010));
        press(2);
        exp_q.push_back(mk(8'h01, 6'b000011));
        press(1);
        exp_q.push_back(mk(8'h00, 6'b000010));
        press(1);
        cmd.temp_high <= 1'b1;
        repeat (10) @(posedge clk_in);
        cmd.temp_high <= 1'b0;
        repeat (4) @(posedge clk_in);
        exp_q.push_back(mk(8'h00, 6'b000000));
        press(0);
        finish_test("diag views");
        exp_q.push_back(mk(`AFS_CODE_CTRL_MEM, 6'b110000));
        cmd.ctrl_mem_err <= 1'b1;
        finish_test("fault after diag");
        cmd.ctrl_mem_err <= 1'b0;
        press(2);
        finish_test("fault held");
        print_verdict();
    end
endmodule
`default_nettype wire
